//--- adc_seq_pkg.sv
// constants, register map and types for the converter readout sequencer
package adc_seq_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned SAMPLE_HZ = 100_000;
  localparam int unsigned CONV_CLK_HZ = 2_000_000;
  localparam int unsigned PERIOD_CYC = CLK_HZ / SAMPLE_HZ;
  localparam int unsigned HALF_CYC = CLK_HZ / (2 * CONV_CLK_HZ);

  // ==========================================================
  // widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned PERIOD_W = 16;
  localparam int unsigned DIV_W = 8;
  localparam int unsigned AVG_MAX_LOG2 = 3;
  localparam int unsigned AVG_LOG_W = 2;
  localparam int unsigned BIT_CNT_W = 4;

  // ==========================================================
  // register offsets (byte addresses, one word each)
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] PERIOD_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] CLKDIV_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] RESULT_OFS = 8'h10;

  // ==========================================================
  // field positions and reset values
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_AVG_LSB = 1;
  localparam int unsigned ST_READY_BIT = 0;
  localparam int unsigned ST_OVERRUN_BIT = 1;
  localparam int unsigned ST_ACTIVE_BIT = 2;
  localparam int unsigned ST_HOLD_BIT = 3;
  localparam logic [PERIOD_W-1:0] PERIOD_RST = PERIOD_W'(PERIOD_CYC);
  localparam logic [DIV_W-1:0] CLKDIV_RST = DIV_W'(HALF_CYC);
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = BIT_CNT_W'(WORD_BITS - 1);

  // ==========================================================
  // sequencer states, gray coded along idle-acq-hold-shift
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACQ = 2'b01,
    ST_HOLD = 2'b11,
    ST_SHIFT = 2'b10
  } seq_state_e;

  // address match used by read and write decode
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

endpackage

//--- conv_clk_gen.sv
// gated conversion clock divider, held low while gated off
`timescale 1ns/1ps
`default_nettype none
module conv_clk_gen
  import adc_seq_pkg::*;
#(
  parameter int unsigned W = DIV_W
) (
  // system
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic enable,
  input wire logic [W-1:0] half,
  // clock out and falling-edge strobe
  output logic conv_clk,
  output logic fall_pulse
);

  logic [W-1:0] cnt;
  logic last;

  // end of a half period; a half of zero acts as one
  assign last = (half <= W'(1)) || (cnt == half - W'(1));
  assign fall_pulse = enable && last && conv_clk;

  // divider counter and clock toggle, low when disabled
  always_ff @(posedge clk) begin
    if (rst || !enable) begin
      cnt <= '0;
      conv_clk <= 1'b0;
    end else if (last) begin
      cnt <= '0;
      conv_clk <= ~conv_clk;
    end else begin
      cnt <= cnt + W'(1);
    end
  end

  // the counter never passes the programmed half period
  div_range_a: assert property (@(posedge clk) disable iff (rst)
    (half > W'(1)) |-> (cnt < half))
    else $error("divider counter beyond half period");

endmodule
`default_nettype wire

//--- sample_averager.sv
// averages 2**n successive conversion words
`timescale 1ns/1ps
`default_nettype none
module sample_averager
  import adc_seq_pkg::*;
#(
  parameter int unsigned WW = WORD_BITS,
  parameter int unsigned ML = AVG_MAX_LOG2
) (
  // system
  input wire logic clk,
  input wire logic rst,
  // incoming words and group size
  input wire logic in_valid,
  input wire logic [WW-1:0] in_data,
  input wire logic [AVG_LOG_W-1:0] avg_log2,
  // averaged result
  output logic out_valid,
  output logic [WW-1:0] out_data
);

  logic signed [WW+ML-1:0] acc;
  logic signed [WW+ML-1:0] sum;
  logic [ML-1:0] cnt;
  logic full;
  logic [ML:0] seen;

  assign sum = acc + (WW+ML)'($signed(in_data));
  assign full = cnt == ML'((1 << avg_log2) - 1);

  // accumulate and emit the mean of each group
  always_ff @(posedge clk) begin
    if (rst) begin
      acc <= '0;
      cnt <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      out_valid <= 1'b0;
      if (in_valid && full) begin
        acc <= '0;
        cnt <= '0;
        out_valid <= 1'b1;
        out_data <= WW'(sum >>> avg_log2);
      end else if (in_valid) begin
        acc <= sum;
        cnt <= cnt + ML'(1);
      end
    end
  end

  // words since last output, checker helper
  always_ff @(posedge clk) begin
    if (rst || out_valid) begin
      seen <= (ML+1)'(in_valid);
    end else if (in_valid) begin
      seen <= seen + (ML+1)'(1);
    end
  end

  group_size_a: assert property (@(posedge clk) disable iff (rst)
    out_valid |-> ($past(seen) + (ML+1)'(1) == (ML+1)'(1 << avg_log2)))
    else $error("average emitted after wrong word count");

endmodule
`default_nettype wire

//--- adc_readout_host.sv
// host sequencer driving a serial sampling converter, APB controlled
// Operation
// - timer paces the sample/hold flag output
// - conversion clock from divider, about 2 MHz
// - conversion clock stopped during acquisition
// - conversion clock held low when hold begins
// - clock enabled right after entering hold
// - busy frames each incoming data word
// - frame sync external, normal, non-inverted
// - word-complete event flagged after last bit
// - acquisition restarts right after last bit
// - sample period programmable, e.g. 96 kSPS
// - default rate 100 kHz, decimation filtering
// - optional averaging of 2**n conversions
`timescale 1ns/1ps
`default_nettype none
module adc_readout_host
  import adc_seq_pkg::*;
(
  // system
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter pins
  output logic host_flag_output,
  output logic conv_clk,
  input wire logic host_receive_frame_input,
  input wire logic serial_data_in
);

  // ==========================================================
  // declarations
  seq_state_e state;
  seq_state_e next_state;
  logic run;
  logic [AVG_LOG_W-1:0] avg_log2;
  logic [PERIOD_W-1:0] period;
  logic [DIV_W-1:0] half;
  logic [PERIOD_W-1:0] per_cnt;
  logic tick;
  logic busy_m;
  logic busy_s;
  logic data_m;
  logic data_s;
  logic clk_en;
  logic fall_pulse;
  logic bit_take;
  logic [BIT_CNT_W-1:0] bit_cnt;
  logic [WORD_BITS-1:0] shift;
  logic word_done;
  logic word_valid;
  logic [WORD_BITS-1:0] word;
  logic avg_valid;
  logic [WORD_BITS-1:0] avg_data;
  logic [WORD_BITS-1:0] result;
  logic ready;
  logic overrun;
  logic acc_phase;
  logic wr_en;
  logic rd_result;
  logic clr_overrun;
  logic mapped;
  logic stop_req;

  // ==========================================================
  // pin synchronisers, two flops each
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_m <= 1'b0;
      busy_s <= 1'b0;
      data_m <= 1'b0;
      data_s <= 1'b0;
    end else begin
      busy_m <= host_receive_frame_input;
      busy_s <= busy_m;
      data_m <= serial_data_in;
      data_s <= data_m;
    end
  end

  // ==========================================================
  // sample timer
  assign tick = run && (per_cnt == period - PERIOD_W'(1));

  // free-running period counter while running
  always_ff @(posedge clk) begin
    if (rst || !run || tick) begin
      per_cnt <= '0;
    end else begin
      per_cnt <= per_cnt + PERIOD_W'(1);
    end
  end

  // ==========================================================
  // sequencer
  assign bit_take = fall_pulse && busy_s;
  assign word_done = bit_take && (bit_cnt == LAST_BIT);

  // next state decode
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (run) begin
          next_state = ST_ACQ;
        end
      end
      ST_ACQ: begin
        if (!run) begin
          next_state = ST_IDLE;
        end else if (tick) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!run) begin
          next_state = ST_IDLE;
        end else if (bit_take) begin
          next_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (!run) begin
          next_state = ST_IDLE;
        end else if (word_done) begin
          next_state = ST_ACQ;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // flag output high in acquisition, low in hold and readout
  always_ff @(posedge clk) begin
    if (rst) begin
      host_flag_output <= 1'b1;
    end else begin
      host_flag_output <= (next_state == ST_IDLE) ||
                          (next_state == ST_ACQ);
    end
  end

  // clock gate follows hold, stopped while acquiring
  always_ff @(posedge clk) begin
    if (rst) begin
      clk_en <= 1'b0;
    end else begin
      clk_en <= (next_state == ST_HOLD) ||
                (next_state == ST_SHIFT);
    end
  end

  // serial word assembly, msb first
  always_ff @(posedge clk) begin
    if (rst || state == ST_ACQ || state == ST_IDLE) begin
      bit_cnt <= '0;
      shift <= '0;
    end else if (bit_take) begin
      bit_cnt <= bit_cnt + BIT_CNT_W'(1);
      shift <= {shift[WORD_BITS-2:0], data_s};
    end
  end

  // completed word strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      word_valid <= 1'b0;
      word <= '0;
    end else begin
      word_valid <= word_done;
      if (word_done) begin
        word <= {shift[WORD_BITS-2:0], data_s};
      end
    end
  end

  // ==========================================================
  // sub blocks
  conv_clk_gen #(
    .W(DIV_W)
  ) u_clk (
    .clk(clk),
    .rst(rst),
    .enable(clk_en && !stop_req),
    .half(half),
    .conv_clk(conv_clk),
    .fall_pulse(fall_pulse)
  );

  sample_averager #(
    .WW(WORD_BITS),
    .ML(AVG_MAX_LOG2)
  ) u_avg (
    .clk(clk),
    .rst(rst),
    .in_valid(word_valid),
    .in_data(word),
    .avg_log2(avg_log2),
    .out_valid(avg_valid),
    .out_data(avg_data)
  );

  // ==========================================================
  // apb register file
  assign pready = 1'b1;
  assign acc_phase = psel && penable;
  assign wr_en = acc_phase && pwrite && mapped;
  assign rd_result = acc_phase && !pwrite && hit(paddr, RESULT_OFS);
  assign clr_overrun = wr_en && hit(paddr, STATUS_OFS) &&
                       pwdata[ST_OVERRUN_BIT];
  // a stop write pulls the clock low one edge before the flag rises
  assign stop_req = wr_en && hit(paddr, CTRL_OFS) &&
                    !pwdata[CTRL_RUN_BIT];
  assign mapped = hit(paddr, CTRL_OFS) || hit(paddr, PERIOD_OFS) ||
                  hit(paddr, CLKDIV_OFS) || hit(paddr, STATUS_OFS) ||
                  hit(paddr, RESULT_OFS);

  // control registers written by software
  always_ff @(posedge clk) begin
    if (rst) begin
      run <= 1'b0;
      avg_log2 <= '0;
      period <= PERIOD_RST;
      half <= CLKDIV_RST;
    end else if (wr_en) begin
      if (hit(paddr, CTRL_OFS)) begin
        run <= pwdata[CTRL_RUN_BIT];
        avg_log2 <= pwdata[CTRL_AVG_LSB +: AVG_LOG_W];
      end
      if (hit(paddr, PERIOD_OFS)) begin
        period <= pwdata[PERIOD_W-1:0];
      end
      if (hit(paddr, CLKDIV_OFS)) begin
        half <= pwdata[DIV_W-1:0];
      end
    end
  end

  // result and ready flag, a new result wins over the read clear
  always_ff @(posedge clk) begin
    if (rst) begin
      result <= '0;
      ready <= 1'b0;
    end else if (avg_valid) begin
      result <= avg_data;
      ready <= 1'b1;
    end else if (rd_result) begin
      ready <= 1'b0;
    end
  end

  // overrun: timer fired before the word finished, set wins
  always_ff @(posedge clk) begin
    if (rst) begin
      overrun <= 1'b0;
    end else if (tick && (state == ST_HOLD || state == ST_SHIFT)) begin
      overrun <= 1'b1;
    end else if (clr_overrun) begin
      overrun <= 1'b0;
    end
  end

  // read data and error captured in the setup cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= !mapped;
      prdata <= '0;
      if (hit(paddr, CTRL_OFS)) begin
        prdata[CTRL_RUN_BIT] <= run;
        prdata[CTRL_AVG_LSB +: AVG_LOG_W] <= avg_log2;
      end
      if (hit(paddr, PERIOD_OFS)) begin
        prdata[PERIOD_W-1:0] <= period;
      end
      if (hit(paddr, CLKDIV_OFS)) begin
        prdata[DIV_W-1:0] <= half;
      end
      if (hit(paddr, STATUS_OFS)) begin
        prdata[ST_READY_BIT] <= ready;
        prdata[ST_OVERRUN_BIT] <= overrun;
        prdata[ST_ACTIVE_BIT] <= state != ST_IDLE;
        prdata[ST_HOLD_BIT] <= !host_flag_output;
      end
      if (hit(paddr, RESULT_OFS)) begin
        prdata[WORD_BITS-1:0] <= result;
      end
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  hold_clk_low_a: assert property (@(posedge clk) disable iff (rst)
    $fell(host_flag_output) |-> !conv_clk && !$past(conv_clk))
    else $error("conversion clock high when hold began");

  acq_clk_stop_a: assert property (@(posedge clk) disable iff (rst)
    host_flag_output |-> !conv_clk)
    else $error("conversion clock running during acquisition");

  hold_clk_on_a: assert property (@(posedge clk) disable iff (rst)
    $fell(host_flag_output) |-> clk_en)
    else $error("clock not enabled with hold");

  tick_hold_a: assert property (@(posedge clk) disable iff (rst)
    (tick && state == ST_ACQ) |=> !host_flag_output ##1 !host_flag_output)
    else $error("hold did not follow timer tick");

  hold_cause_a: assert property (@(posedge clk) disable iff (rst)
    $fell(host_flag_output) |-> $past(tick))
    else $error("hold entered without timer tick");

  resume_acq_a: assert property (@(posedge clk) disable iff (rst)
    (word_done && run) |=> host_flag_output && !clk_en)
    else $error("acquisition not restarted after last bit");

  frame_take_a: assert property (@(posedge clk) disable iff (rst)
    bit_take |-> busy_s && !host_flag_output)
    else $error("bit taken outside busy frame");

  word_len_a: assert property (@(posedge clk) disable iff (rst)
    word_done |=> word_valid && word[0] == $past(data_s))
    else $error("word ended at wrong bit");

  ready_set_a: assert property (@(posedge clk) disable iff (rst)
    avg_valid |=> ready && result == $past(avg_data))
    else $error("result not flagged ready");

endmodule
`default_nettype wire

//--- conv_model.sv
// behavioural serial sampling converter facing the host sequencer
`timescale 1ns/1ps
`default_nettype none
module conv_model (
  // control from host
  input wire logic host_flag_output,
  input wire logic conv_clk,
  // frame and data to host
  output logic host_receive_frame_input,
  output logic serial_data_in
);
  logic [15:0] words[$];
  logic [15:0] held_word;
  int sent;
  bit converting;

  // idle lines
  initial begin
    host_receive_frame_input = 1'b0;
    serial_data_in = 1'b0;
    converting = 0;
    sent = 0;
  end

  // sample frozen when hold begins, corrected code is ideal
  always @(negedge host_flag_output) begin
    held_word = (words.size() > 0) ? words.pop_front() : 16'h0000;
    sent = 0;
    converting = 1;
  end

  // one bit launched per rising clock edge, msb first
  always @(posedge conv_clk) begin
    if (converting && sent < 16) begin
      host_receive_frame_input <= 1'b1;
      serial_data_in <= held_word[15 - sent];
      sent++;
    end
  end

  // frame closes once the last bit was taken
  always @(negedge conv_clk) begin
    if (converting && sent == 16) begin
      host_receive_frame_input <= 1'b0;
      serial_data_in <= ~serial_data_in;
      converting = 0;
    end
  end

  // new acquisition aborts any frame
  always @(posedge host_flag_output) begin
    if (converting) begin
      host_receive_frame_input <= 1'b0;
      serial_data_in <= ~serial_data_in;
      converting = 0;
    end
  end
endmodule
`default_nettype wire

//--- tb_adc_readout_host.sv
// self-checking bench for the converter readout sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_adc_readout_host;
  import adc_seq_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, r;
  logic host_flag_output, conv_clk, busy, sdata, pf, pc;
  int num_errors, n_compared, cyc, last_hold, since_fall, hi_len, falls;
  int period_set, half_set, seed, k;
  bit have_prev, mon_on, first_rise;

  adc_readout_host dut_u (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_flag_output(host_flag_output), .conv_clk(conv_clk),
    .host_receive_frame_input(busy), .serial_data_in(sdata));

  conv_model partner_u (.host_flag_output(host_flag_output),
    .conv_clk(conv_clk), .host_receive_frame_input(busy),
    .serial_data_in(sdata));

  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (num_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [15:0] avg_of(input int sum, input int n);
    return 16'(sum >>> n);
  endfunction

  // one averaging group through the serial link
  task automatic run_group(input int n, input int per,
                           input logic [15:0] fixed, input bit rnd);
    logic [15:0] w;
    logic [31:0] st;
    int sum;
    int i;
    sum = 0;
    for (i = 0; i < (1 << n); i++) begin
      w = rnd ? 16'($random(seed)) : fixed;
      partner_u.words.push_back(w);
      sum += int'($signed(w));
    end
    period_set = per;
    have_prev = 0;
    apb(1'b1, PERIOD_OFS, 32'(per), r, e);
    apb(1'b1, CTRL_OFS, 32'((n << 1) | 1), r, e);
    st = 32'h0;
    for (i = 0; i < 3000 && st[ST_READY_BIT] !== 1'b1; i++)
      apb(1'b0, STATUS_OFS, 32'h0, st, e);
    check(32'(st[ST_READY_BIT]), 32'h1);
    check(32'(st[ST_ACTIVE_BIT]), 32'h1);
    apb(1'b0, RESULT_OFS, 32'h0, r, e);
    check(r, {16'h0000, avg_of(sum, n)});
    apb(1'b0, STATUS_OFS, 32'h0, r, e);
    check(32'(r[ST_READY_BIT]), 32'h0);
    apb(1'b1, CTRL_OFS, 32'h0, r, e);
  endtask

  // ==========================================================
  // clock, watchdog and wire monitor
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #200000;
    num_errors++;
    give_verdict();
  end

  always @(posedge clk) begin
    cyc++;
    since_fall++;
    if (rst === 1'b0) begin
      if (pf === 1'b1 && host_flag_output === 1'b1)
        check(32'(conv_clk), 32'h0);
      if (pf === 1'b1 && host_flag_output === 1'b0) begin
        check(32'(conv_clk), 32'h0);
        if (have_prev && mon_on)
          check(32'(cyc - last_hold), 32'(period_set));
        have_prev = 1;
        last_hold = cyc;
        falls = 0;
        first_rise = 1;
      end
      if (pc === 1'b0 && conv_clk === 1'b1 && first_rise) begin
        check(32'(cyc - last_hold), 32'(half_set));
        first_rise = 0;
      end
      if (pc === 1'b1 && conv_clk === 1'b0) begin
        if (mon_on)
          check(32'(hi_len), 32'(half_set));
        falls++;
        since_fall = 0;
      end
      if (pf === 1'b0 && host_flag_output === 1'b1 && mon_on) begin
        check(32'(falls), 32'd16);
        check(32'(since_fall), 32'd0);
      end
    end
    hi_len = (conv_clk === 1'b1) ? hi_len + 1 : 0;
    pf = host_flag_output;
    pc = conv_clk;
  end

  // ==========================================================
  // main sequence
  initial begin
    seed = 32'hb8cf86e0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    mon_on = 1;
    half_set = 50;
    repeat (8) @(posedge clk);
    check(32'(host_flag_output), 32'h1);
    check(32'(conv_clk), 32'h0);
    rst <= 1'b0;
    apb(1'b0, PERIOD_OFS, 32'h0, r, e);
    check(r, 32'd2000);
    apb(1'b0, CLKDIV_OFS, 32'h0, r, e);
    check(r, 32'd50);
    apb(1'b0, CTRL_OFS, 32'h0, r, e);
    check(r, 32'h0);
    apb(1'b0, 8'h14, 32'h0, r, e);
    check({r[30:0], e}, 32'h1);
    half_set = 4;
    apb(1'b1, CLKDIV_OFS, 32'h4, r, e);
    run_group(1, 400, 16'h8000, 0);
    run_group(2, 400, 16'h7FFF, 0);
    run_group(0, 400, 16'hFFFF, 0);
    for (k = 0; k < 4; k++)
      run_group(k, 400, 16'h0000, 1);
    run_group(0, 2083, 16'h0000, 1);
    // ticks faster than a readout are refused and flagged
    mon_on = 0;
    apb(1'b1, PERIOD_OFS, 32'd100, r, e);
    apb(1'b1, CTRL_OFS, 32'h1, r, e);
    repeat (1000) @(posedge clk);
    apb(1'b1, CTRL_OFS, 32'h0, r, e);
    apb(1'b0, STATUS_OFS, 32'h0, r, e);
    check(32'(r[ST_OVERRUN_BIT]), 32'h1);
    check(32'(r[ST_ACTIVE_BIT]), 32'h0);
    apb(1'b1, STATUS_OFS, 32'h2, r, e);
    apb(1'b0, STATUS_OFS, 32'h0, r, e);
    check(32'(r[ST_OVERRUN_BIT]), 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
